// ---- common/dpf_pkg.sv ----
package dpf_pkg;
   localparam logic [7:0] CMD_CONFIG_WR = 8'h70;
   localparam logic [7:0] CMD_SLEEP_WR = 8'h71;
   localparam logic [7:0] CMD_TOGGLE_BITS_WR = 8'h73;
   localparam logic [7:0] CMD_FAULT_WR = 8'h76;
   localparam logic [7:0] CMD_CONFIG_RD = 8'hf0;
   localparam logic [7:0] CMD_SLEEP_RD = 8'hf1;
   localparam logic [7:0] CMD_FAULT_RD = 8'hf6;
   localparam logic [3:0] CMD_UPDATE_HI = 4'h6; // update channel n
   localparam logic [3:0] CMD_WRUPD_HI = 4'h3; // write and update n
   localparam logic [3:0] CMD_UPDATE_ALL_HI = 4'h9;
   localparam logic [15:0] SLEEP_RESET = 16'h0000;
   localparam logic [15:0] SLEEP_ALL = 16'hffff;
   localparam int RESTART_BIT = 15;
   localparam int GUARD_BIT = 2;
   localparam int VREF_BIT = 1;
   localparam int CHECK_BIT = 0;
   localparam int OVERHEAT_BIT = 2;
   localparam int COUNT_BIT = 1;
   localparam int INTEGRITY_BIT = 0;
   localparam logic [6:0] COUNT_SHORT = 7'd24;
   localparam logic [6:0] COUNT_WORD = 7'd32;
   localparam logic [5:0] CHECK_POLY = 6'h03; // x^6 + x + 1
   localparam int WAKE_US = 50;
   localparam int CLK_MHZ = 200;
   localparam int WAKE_CYCLES = WAKE_US * CLK_MHZ;

   typedef struct packed {
      logic [7:0] cmd;
      logic [15:0] data;
      logic good_count;
      logic check_ok;
   } dpf_frame_t;
endpackage : dpf_pkg

// ---- verilog/dpf_ctrl.sv ----
`timescale 1ns/1ps
module dpf_ctrl
   import dpf_pkg::*;
(
   input wire logic REF_CLK_IN,
   input wire logic RESETN_IN,
   input wire logic LINK_CLK_IN,
   input wire logic LINK_DATA_IN,
   input wire logic FRAME_SELECT_LOAD_N_IN,
   input wire logic ASYNC_LOAD_PIN_N_IN,
   input wire logic CLEAR_INPUT_PIN_N_IN,
   input wire logic OVERTEMP_IN,
   output logic LINK_DATA_OUT,
   output logic LINK_DATA_OE_N_OUT,
   output logic ALARM_OE_N_OUT,
   output logic [15:0] CHANNEL_SLEEP_OUT,
   output logic CHIP_SLEEP_OUT,
   output logic OUTPUT_LOAD_OUT,
   output logic OUTSIDE_VREF_SELECT_OUT,
   output logic OVERHEAT_GUARD_OFF_OUT,
   output logic THERMAL_SHUTDOWN_OUT
);

   ////////////////////////////////////////////////////////////////////
   // link domain: shift in, count clocks, run the frame check
   // the shifter is not wiped when the select rises: the core reads the
   // finished frame a few core clocks later, so the contents must stay
   // put until the first clock of the next frame. a start flag, set by
   // the select pin, makes that first clock begin a fresh frame instead.
   typedef struct packed {
      logic fresh;
      logic [31:0] shift;
      logic [6:0] count;
      logic [5:0] crc;
   } dpf_link_t;

   // the answer side only counts falling edges within a frame
   typedef struct packed {
      logic [6:0] tx_cnt;
   } dpf_tx_t;

   dpf_link_t lk_ff;
   dpf_link_t nxt_lk;
   dpf_tx_t tx_ff;
   dpf_tx_t nxt_tx;
   logic [31:0] tx_word; // answer word; command set at frame end, register bits can change while a frame runs
   logic [31:0] base_shift;
   logic [6:0] base_count;
   logic [5:0] base_crc;

   // six bit running check over the first 26 bits of a 32 bit frame;
   // it starts from zero at every frame start, like the host's own
   always_comb
   begin
      base_shift = lk_ff.fresh ? 32'h0000_0000 : lk_ff.shift;
      base_count = lk_ff.fresh ? 7'h00 : lk_ff.count;
      base_crc = lk_ff.fresh ? 6'h00 : lk_ff.crc;
      nxt_lk = lk_ff;
      nxt_lk.fresh = 1'b0;
      nxt_lk.shift = {base_shift[30:0], LINK_DATA_IN};
      nxt_lk.count = base_count + 7'h01;
      nxt_lk.crc = base_crc;
      if (base_count < 7'h1a)
      begin
         nxt_lk.crc = {base_crc[4:0], 1'b0}
            ^ ((base_crc[5] ^ LINK_DATA_IN) ? CHECK_POLY : 6'h00);
      end
   end

   // a high select only arms the start flag; the frame waits for the core
   always_ff @(posedge LINK_CLK_IN or posedge FRAME_SELECT_LOAD_N_IN)
   begin
      if (FRAME_SELECT_LOAD_N_IN)
      begin
         lk_ff.fresh <= 1'b1;
      end
      else
      begin
         lk_ff <= nxt_lk;
      end
   end

   // falling edge count picks the answer bit
   always_comb
   begin
      nxt_tx.tx_cnt = tx_ff.tx_cnt + 7'h01;
   end

   // the answer word takes its command at frame end, but the load pin, clear pin and
   // overheat can change its register bits mid frame; this domain reads it with no copy
   always_ff @(negedge LINK_CLK_IN or posedge FRAME_SELECT_LOAD_N_IN)
   begin
      if (FRAME_SELECT_LOAD_N_IN)
      begin
         tx_ff <= '0;
      end
      else
      begin
         tx_ff <= nxt_tx;
      end
   end

   // past bit 31 of a long frame the line shows zeros
   always_comb
   begin
      LINK_DATA_OUT = (tx_ff.tx_cnt < 7'h20)
         ? tx_word[5'(7'h1f - tx_ff.tx_cnt)] : 1'b0;
      LINK_DATA_OE_N_OUT = FRAME_SELECT_LOAD_N_IN;
   end

   ////////////////////////////////////////////////////////////////////
   // core domain: select edge arrives through a three stage sync
   typedef struct packed {
      logic [2:0] sel_sync;
      logic [1:0] load_sync;
      logic [1:0] clr_sync;
      logic [1:0] heat_sync;
      logic sel_d;
      logic clr_d;
      logic [15:0] sleep;
      logic guard_off;
      logic vref_out;
      logic check_en;
      logic [2:0] flags;
      logic alarm;
      logic load;
      logic load_d;
      logic [7:0] last_cmd;
   } dpf_core_t;

   dpf_core_t c_ff;
   dpf_core_t nxt_c;
   dpf_frame_t fr;
   logic sel_rise;
   logic load_low;
   logic load_fall;
   logic clr_fall;
   logic check_skip;
   logic run;
   logic is_update;
   logic [3:0] chan;
   logic restart;
   logic [2:0] fault_set;

   // frame contents hold from select rise until the next frame's first
   // clock; the core reads them only at the synchronised select rise,
   // long after the last link edge, so no bit is caught mid-change
   always_comb
   begin
      fr.cmd = (lk_ff.count == COUNT_SHORT) ? lk_ff.shift[23:16]
                                            : lk_ff.shift[31:24];
      fr.data = (lk_ff.count == COUNT_SHORT) ? lk_ff.shift[15:0]
                                             : lk_ff.shift[23:8];
      fr.good_count = (lk_ff.count == COUNT_SHORT)
         || ((lk_ff.count != 7'd0) && (lk_ff.count[4:0] == 5'd0));
      fr.check_ok = (lk_ff.count == COUNT_WORD)
         && (lk_ff.crc == lk_ff.shift[5:0]);
   end

   // decode of the frame just completed
   always_comb
   begin
      sel_rise = c_ff.sel_sync[2] & ~c_ff.sel_d;
      load_low = ~c_ff.load_sync[1];
      // one pulse per low level, however long the pin stays low
      load_fall = ~c_ff.load_sync[1] & c_ff.load_d;
      clr_fall = ~c_ff.clr_sync[1] & c_ff.clr_d;
      check_skip = (fr.cmd == CMD_CONFIG_WR) || (fr.cmd == CMD_FAULT_WR)
         || (fr.cmd == CMD_CONFIG_RD) || (fr.cmd == CMD_FAULT_RD);
      run = sel_rise && fr.good_count
         && (!c_ff.check_en || check_skip || fr.check_ok);
      chan = fr.cmd[3:0];
      is_update = (fr.cmd[7:4] == CMD_UPDATE_HI)
         || (fr.cmd[7:4] == CMD_WRUPD_HI);
      restart = run && (fr.cmd == CMD_CONFIG_WR) && fr.data[RESTART_BIT];
      fault_set = '0;
      fault_set[OVERHEAT_BIT] = c_ff.heat_sync[1] & ~c_ff.guard_off;
      fault_set[COUNT_BIT] = sel_rise & ~fr.good_count;
      fault_set[INTEGRITY_BIT] = sel_rise && fr.good_count
         && c_ff.check_en && !check_skip && !fr.check_ok;
   end

   // answer for the next frame
   always_comb
   begin
      tx_word = '0;
      case (c_ff.last_cmd)
         CMD_SLEEP_RD: tx_word = {c_ff.last_cmd, c_ff.sleep, 8'h00};
         CMD_FAULT_RD: tx_word = {c_ff.last_cmd, 13'h0000, c_ff.flags,
                                  8'h00};
         CMD_CONFIG_RD: tx_word = {c_ff.last_cmd, 13'h0000, c_ff.guard_off,
                                   c_ff.vref_out, c_ff.check_en, 8'h00};
         default: tx_word = '0;
      endcase
   end

   // next state of the control core
   always_comb
   begin
      nxt_c = c_ff;
      nxt_c.sel_sync = {c_ff.sel_sync[1:0], FRAME_SELECT_LOAD_N_IN};
      nxt_c.load_sync = {c_ff.load_sync[0], ASYNC_LOAD_PIN_N_IN};
      nxt_c.clr_sync = {c_ff.clr_sync[0], CLEAR_INPUT_PIN_N_IN};
      nxt_c.heat_sync = {c_ff.heat_sync[0], OVERTEMP_IN};
      nxt_c.sel_d = c_ff.sel_sync[2];
      nxt_c.clr_d = c_ff.clr_sync[1];
      nxt_c.load_d = c_ff.load_sync[1];
      nxt_c.load = 1'b0;
      if (sel_rise)
      begin
         nxt_c.last_cmd = fr.cmd;
      end
      // load low wakes all; update waits
      // a low inside a frame only wakes; the copy comes at the frame end if the pin is still low
      if (load_low)
      begin
         nxt_c.sleep = SLEEP_RESET;
      end
      if (load_fall && c_ff.sel_sync[2] && !sel_rise)
      begin
         nxt_c.load = 1'b1;
      end
      if (run)
      begin
         if (is_update)
         begin
            nxt_c.sleep[chan] = 1'b0;
            nxt_c.load = 1'b1;
         end
         // chip-wide update or toggle wakes all
         if ((fr.cmd[7:4] == CMD_UPDATE_ALL_HI)
            || (fr.cmd == CMD_TOGGLE_BITS_WR))
         begin
            nxt_c.sleep = SLEEP_RESET;
            nxt_c.load = (fr.cmd[7:4] == CMD_UPDATE_ALL_HI);
         end
         if ((fr.cmd == CMD_SLEEP_WR) && !load_low)
         begin
            nxt_c.sleep = fr.data;
         end
         if (fr.cmd == CMD_CONFIG_WR)
         begin
            nxt_c.guard_off = fr.data[GUARD_BIT];
            nxt_c.vref_out = fr.data[VREF_BIT];
            nxt_c.check_en = fr.data[CHECK_BIT];
         end
         if (fr.cmd == CMD_FAULT_WR)
         begin
            nxt_c.flags = fr.data[2:0];
         end
      end
      // load still low at frame end
      if (sel_rise && load_low)
      begin
         nxt_c.load = 1'b1;
      end
      // alarm released at frame end, then set again if a fault is raised
      if (sel_rise)
      begin
         nxt_c.alarm = 1'b0;
      end
      // sticky; new events win over a clear
      nxt_c.flags = nxt_c.flags | fault_set;
      if (|fault_set)
      begin
         nxt_c.alarm = 1'b1;
      end
      // restart and clear wipe sleep and flags
      if (restart || clr_fall)
      begin
         nxt_c.sleep = SLEEP_RESET;
         nxt_c.flags = fault_set;
         nxt_c.guard_off = 1'b0;
         nxt_c.vref_out = 1'b0;
         nxt_c.check_en = 1'b0;
      end
   end

   always_ff @(posedge REF_CLK_IN or negedge RESETN_IN)
   begin
      if (!RESETN_IN)
      begin
         c_ff <= '0;
         c_ff.sel_sync <= 3'b111;
         c_ff.load_sync <= 2'b11;
         c_ff.clr_sync <= 2'b11;
         c_ff.sel_d <= 1'b1;
         c_ff.clr_d <= 1'b1;
         c_ff.load_d <= 1'b1;
         c_ff.sleep <= SLEEP_RESET;
      end
      else
      begin
         c_ff <= nxt_c;
      end
   end

   // outputs; alarm enable is low while pulling the pin low
   always_comb
   begin
      ALARM_OE_N_OUT = ~c_ff.alarm;
      CHANNEL_SLEEP_OUT = c_ff.sleep;
      CHIP_SLEEP_OUT = (c_ff.sleep == SLEEP_ALL);
      OUTPUT_LOAD_OUT = c_ff.load;
      OUTSIDE_VREF_SELECT_OUT = c_ff.vref_out;
      OVERHEAT_GUARD_OFF_OUT = c_ff.guard_off;
      THERMAL_SHUTDOWN_OUT = c_ff.flags[OVERHEAT_BIT] & ~c_ff.guard_off;
   end
endmodule : dpf_ctrl

// ---- dv/dpf_host.sv ----
`timescale 1ns/1ps
module dpf_host (
   output logic link_clk_out,
   output logic link_data_out,
   output logic select_n_out,
   input wire logic answer_in
);
   // idle: select high, clock low
   initial
   begin
      link_clk_out = 1'b0;
      link_data_out = 1'b0;
      select_n_out = 1'b1;
   end
   // msb first, answer taken on rising clock
   task automatic frame(input logic [31:0] w, input int n,
      output logic [31:0] rd);
      rd = 32'h0000_0000;
      #1.3 select_n_out = 1'b0;
      for (int i = n - 1; i >= 0; i--)
      begin
         link_data_out = w[i];
         #7.5 link_clk_out = 1'b1;
         rd = {rd[30:0], answer_in};
         #7.5 link_clk_out = 1'b0;
      end
      #7.5 select_n_out = 1'b1;
      // a released line must not look held
      link_data_out = ~link_data_out;
   endtask : frame
endmodule : dpf_host

// ---- dv/dpf_ctrl_props.sv ----
`timescale 1ns/1ps
module dpf_ctrl_props (
   input wire logic REF_CLK_IN,
   input wire logic RESETN_IN,
   input wire logic FRAME_SELECT_LOAD_N_IN,
   input wire logic ASYNC_LOAD_PIN_N_IN,
   input wire logic OVERTEMP_IN,
   input wire logic LINK_DATA_OE_N_OUT,
   input wire logic ALARM_OE_N_OUT,
   input wire logic [15:0] CHANNEL_SLEEP_OUT,
   input wire logic CHIP_SLEEP_OUT,
   input wire logic OUTPUT_LOAD_OUT,
   input wire logic OVERHEAT_GUARD_OFF_OUT,
   input wire logic THERMAL_SHUTDOWN_OUT
);
   logic [3:0] since_rise_ff;
   // cycles since frame end, saturating so long gaps stay cheap
   always_ff @(posedge REF_CLK_IN or negedge RESETN_IN)
      if (!RESETN_IN)
         since_rise_ff <= 4'hf;
      else if ($rose(FRAME_SELECT_LOAD_N_IN))
         since_rise_ff <= 4'h0;
      else if (since_rise_ff != 4'hf)
         since_rise_ff <= since_rise_ff + 4'h1;
   ////////////////////////////////////////
   default clocking
      @(posedge REF_CLK_IN);
   endclocking
   default disable iff (!RESETN_IN);
   oe_follows_a: assert property (
      LINK_DATA_OE_N_OUT == FRAME_SELECT_LOAD_N_IN) else $error("oe wrong");
   chip_sleep_a: assert property (
      $stable(CHANNEL_SLEEP_OUT) |-> CHIP_SLEEP_OUT == (&CHANNEL_SLEEP_OUT))
      else $error("chip sleep wrong");
   load_single_a: assert property (
      OUTPUT_LOAD_OUT |=> !OUTPUT_LOAD_OUT) else $error("load too long");
   load_idle_a: assert property (
      $fell(ASYNC_LOAD_PIN_N_IN) && FRAME_SELECT_LOAD_N_IN
      && since_rise_ff > 4'h8 |-> ##[1:6] OUTPUT_LOAD_OUT) else $error("no load");
   load_defer_a: assert property (
      !FRAME_SELECT_LOAD_N_IN && !$past(FRAME_SELECT_LOAD_N_IN, 8)
      |-> !OUTPUT_LOAD_OUT) else $error("load inside frame");
   overheat_a: assert property (
      OVERTEMP_IN && !OVERHEAT_GUARD_OFF_OUT |-> ##[1:6]
      (THERMAL_SHUTDOWN_OUT || OVERHEAT_GUARD_OFF_OUT)) else $error("no stop");
   alarm_on_a: assert property (
      $rose(THERMAL_SHUTDOWN_OUT) |-> ##[0:3] !ALARM_OE_N_OUT)
      else $error("alarm not pulled");
   alarm_free_a: assert property (
      $rose(ALARM_OE_N_OUT) |-> since_rise_ff < 4'h9)
      else $error("alarm freed early");
endmodule : dpf_ctrl_props

bind dpf_ctrl dpf_ctrl_props PROPS (.REF_CLK_IN(REF_CLK_IN),
   .RESETN_IN(RESETN_IN), .FRAME_SELECT_LOAD_N_IN(FRAME_SELECT_LOAD_N_IN),
   .ASYNC_LOAD_PIN_N_IN(ASYNC_LOAD_PIN_N_IN), .OVERTEMP_IN(OVERTEMP_IN),
   .LINK_DATA_OE_N_OUT(LINK_DATA_OE_N_OUT), .ALARM_OE_N_OUT(ALARM_OE_N_OUT),
   .CHANNEL_SLEEP_OUT(CHANNEL_SLEEP_OUT), .CHIP_SLEEP_OUT(CHIP_SLEEP_OUT),
   .OUTPUT_LOAD_OUT(OUTPUT_LOAD_OUT),
   .OVERHEAT_GUARD_OFF_OUT(OVERHEAT_GUARD_OFF_OUT),
   .THERMAL_SHUTDOWN_OUT(THERMAL_SHUTDOWN_OUT));

// ---- dv/tb_top.sv ----
`timescale 1ns/1ps
module tb_top
   import dpf_pkg::*;
;
   logic clk, rst_n, lclk, ldat, sel_n, async_load_pin_n, clr_n, hot;
   logic sdo, oe_n, alarm_n, chip, load, vref, guard, shut;
   logic [15:0] sleep;
   logic [31:0] rnd, rd;
   int n_errors = 0;
   int comparisons = 0;
   int loads = 0;
   int base;
   dpf_ctrl DUT (.REF_CLK_IN(clk), .RESETN_IN(rst_n), .LINK_CLK_IN(lclk),
      .LINK_DATA_IN(ldat), .FRAME_SELECT_LOAD_N_IN(sel_n),
      .ASYNC_LOAD_PIN_N_IN(async_load_pin_n), .CLEAR_INPUT_PIN_N_IN(clr_n),
      .OVERTEMP_IN(hot), .LINK_DATA_OUT(sdo), .LINK_DATA_OE_N_OUT(oe_n),
      .ALARM_OE_N_OUT(alarm_n), .CHANNEL_SLEEP_OUT(sleep),
      .CHIP_SLEEP_OUT(chip), .OUTPUT_LOAD_OUT(load),
      .OUTSIDE_VREF_SELECT_OUT(vref), .OVERHEAT_GUARD_OFF_OUT(guard),
      .THERMAL_SHUTDOWN_OUT(shut));
   dpf_host HOST (.link_clk_out(lclk), .link_data_out(ldat),
      .select_n_out(sel_n), .answer_in(sdo));
   ////////////////////////////////////////
   initial
   begin
      clk = 1'b0;
      forever
         #2.5 clk = ~clk;
   end
   // counts output update pulses
   always @(posedge clk)
      if (load === 1'b1)
         loads++;
   task automatic step(input int n);
      repeat (n) @(negedge clk);
   endtask : step
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      comparisons++;
      if (got !== exp)
      begin
         n_errors++;
         $display("wrong value at %0t: %h vs %h", $time, got, exp);
      end
   endtask : chk
   function automatic logic [31:0] nxt_rnd(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction : nxt_rnd
   // check code over the first 26 bits, msb first from zero
   function automatic logic [5:0] crc6(input logic [25:0] d);
      logic [5:0] c;
      c = 6'h00;
      for (int i = 25; i >= 0; i--)
         c = {c[4:0], 1'b0} ^ ((c[5] ^ d[i]) ? CHECK_POLY : 6'h00);
      return c;
   endfunction : crc6
   task automatic send(input logic [7:0] c, input logic [15:0] d,
      input int n = 32, input logic bad = 1'b0);
      logic [25:0] h;
      h = {c, d, 2'b00};
      HOST.frame({h, crc6(h) ^ {5'h00, bad}}, n, rd);
      step(12);
   endtask : send
   // the second frame carries the answer to the first
   task automatic rdchk(input logic [7:0] c, input logic [15:0] exp);
      send(c, 16'h0000);
      send(c, 16'h0000);
      chk(rd[23:8], exp);
   endtask : rdchk
   task automatic clear_pulse;
      @(posedge clk) clr_n <= 1'b0;
      step(6);
      @(posedge clk) clr_n <= 1'b1;
      step(10);
   endtask : clear_pulse
   task automatic finish_test;
      if (n_errors == 0 && comparisons > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask : finish_test
   // hang guard, well past the expected run
   initial
   begin
      #400000;
      n_errors++;
      finish_test();
   end
   initial
   begin
      rst_n = 1'b0;
      async_load_pin_n = 1'b1;
      clr_n = 1'b1;
      hot = 1'b0;
      rnd = 32'h0001_4bab;
      step(16);
      @(posedge clk) rst_n <= 1'b1;
      step(4);
      chk(sleep, SLEEP_RESET);
      chk({13'h0000, alarm_n, vref, guard}, 16'h0004);
      repeat (4)
      begin
         rnd = nxt_rnd(rnd);
         send(CMD_SLEEP_WR, rnd[15:0]);
         chk(sleep, rnd[15:0]);
         rdchk(CMD_SLEEP_RD, rnd[15:0]);
      end
      send(CMD_SLEEP_WR, SLEEP_ALL);
      chk({15'h0000, chip}, 16'h0001);
      send({CMD_UPDATE_HI, 4'h5}, 16'h0000);
      step(WAKE_CYCLES);
      chk({chip, sleep[14:0]}, 16'h7fdf);
      clear_pulse();
      chk(sleep, SLEEP_RESET);
      // plain load pin pulse, then one held across a frame end
      base = loads;
      @(posedge clk) async_load_pin_n <= 1'b0;
      step(10);
      @(posedge clk) async_load_pin_n <= 1'b1;
      step(10);
      chk(16'(loads - base), 16'h0001);
      base = loads;
      fork
         send(CMD_SLEEP_WR, SLEEP_ALL);
         begin
            step(40);
            @(posedge clk) async_load_pin_n <= 1'b0;
         end
      join
      @(posedge clk) async_load_pin_n <= 1'b1;
      step(10);
      chk(sleep, SLEEP_RESET);
      chk(16'(loads - base), 16'h0001);
      send(CMD_SLEEP_WR, SLEEP_ALL);
      send(CMD_CONFIG_WR, 16'h8000);
      chk(sleep, SLEEP_RESET);
      rdchk(CMD_CONFIG_RD, 16'h0000);
      send(CMD_CONFIG_WR, 16'h0006);
      chk({14'h0000, guard, vref}, 16'h0003);
      rdchk(CMD_CONFIG_RD, 16'h0006);
      @(posedge clk) hot <= 1'b1;
      step(10);
      chk({15'h0000, shut}, 16'h0000);
      send(CMD_CONFIG_WR, 16'h0000);
      @(posedge clk) hot <= 1'b0;
      step(6);
      chk({14'h0000, shut, alarm_n}, 16'h0002);
      rdchk(CMD_FAULT_RD, 16'h0004);
      send(CMD_FAULT_WR, 16'h0003);
      rdchk(CMD_FAULT_RD, 16'h0003);
      send(CMD_FAULT_WR, 16'h0000);
      rdchk(CMD_FAULT_RD, 16'h0000);
      chk({14'h0000, shut, alarm_n}, 16'h0001);
      send(CMD_SLEEP_WR, SLEEP_ALL, 25);
      chk({sleep[0], 14'h0000, alarm_n}, 16'h0000);
      rdchk(CMD_FAULT_RD, 16'h0002);
      clear_pulse();
      rdchk(CMD_FAULT_RD, 16'h0000);
      send(CMD_CONFIG_WR, 16'h0001);
      send(CMD_SLEEP_WR, 16'h00f0, 32, 1'b1);
      chk(sleep, SLEEP_RESET);
      rdchk(CMD_FAULT_RD, 16'h0001);
      send(CMD_SLEEP_WR, 16'h00f0);
      chk(sleep, 16'h00f0);
      send(CMD_CONFIG_WR, 16'h0000, 32, 1'b1);
      send(CMD_SLEEP_WR, 16'h0f00, 32, 1'b1);
      chk(sleep, 16'h0f00);
      finish_test();
   end
endmodule : tb_top
